// ===== rtl/ifa_pkg.sv
// Constants shared by the input function assignment block
package ifa_pkg;
	localparam int IFA_CODE_W = 7;
	localparam int IFA_HW_N = 6;
	localparam int IFA_COMM_N = 16;
	localparam int IFA_IN_N = IFA_HW_N + IFA_COMM_N;
	localparam int IFA_SYNC_N = 3;
	localparam int IFA_ADDR_W = 4;
	typedef logic [IFA_CODE_W-1:0] ifa_code_t;
	localparam ifa_code_t IFA_FN_NONE = 7'h00;
	localparam ifa_code_t IFA_FN_DRIVE_ENABLE = 7'h01;
	localparam ifa_code_t IFA_FN_FORWARD_RUN = 7'h02;
	localparam ifa_code_t IFA_FN_REVERSE_RUN = 7'h03;
	localparam ifa_code_t IFA_FN_BEGIN_POS = 7'h04;
	localparam ifa_code_t IFA_FN_HOMING_REQUEST = 7'h05;
	localparam ifa_code_t IFA_FN_POS_LIMIT = 7'h07;
	localparam ifa_code_t IFA_FN_NEG_LIMIT = 7'h08;
	localparam ifa_code_t IFA_FN_FORCED_STOP = 7'h0A;
	localparam ifa_code_t IFA_FN_FAULT_CLEAR = 7'h0B;
	localparam ifa_code_t IFA_FN_ADDR_BIT0 = 7'h3C;
	localparam ifa_code_t IFA_FN_INTERRUPT = 7'h31;
	localparam logic [IFA_HW_N-1:0] IFA_HW_RESET = 6'h00;
	localparam logic [IFA_ADDR_W-1:0] IFA_ADDR_RESET = 4'h0;
endpackage : ifa_pkg

// ===== rtl/ifa_pin_if.sv
// Interface carrying the synchronised hardware input levels
`timescale 1ns/1ps
interface ifa_pin_if;
	import ifa_pkg::*;
	logic [IFA_HW_N-1:0] level;
	modport producer (output level);
	modport consumer (input level);
endinterface : ifa_pin_if

// ===== rtl/ifa_pin_sync.sv
// Three-stage synchroniser for the hardware input terminals
`timescale 1ns/1ps
module ifa_pin_sync
	import ifa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [IFA_HW_N-1:0] pinRaw,
	ifa_pin_if.producer pins
);
	logic [IFA_HW_N-1:0] meta_q, meta_d;
	logic [IFA_HW_N-1:0] mid_q, mid_d;
	logic [IFA_HW_N-1:0] last_q, last_d;
	logic [IFA_HW_N-1:0] stable_q, stable_d;

	always_comb
	begin
		meta_d = pinRaw;
		mid_d = meta_q;
		last_d = mid_q;
		// Only accept a bit once the two later stages agree
		for (int i = 0; i < IFA_HW_N; i++)
			stable_d[i] = (mid_q[i] == last_q[i]) ? last_q[i] : stable_q[i];
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			meta_q <= IFA_HW_RESET;
			mid_q <= IFA_HW_RESET;
			last_q <= IFA_HW_RESET;
			stable_q <= IFA_HW_RESET;
		end
		else
		begin
			meta_q <= meta_d;
			mid_q <= mid_d;
			last_q <= last_d;
			stable_q <= stable_d;
		end
	end

	assign pins.level = stable_q;
endmodule : ifa_pin_sync

// ===== rtl/ifa_input_function_assignment.sv
// Routes hardware and communication inputs to drive control functions
// Overview of operation
// RULE1 - Codes: 1 enable, 2/3 run, 4 positioning, 5 homing, 7/8 limits, 10, 11, 60-63.
// RULE2 - Each code maps to one function; a hardware input carrying it drives it.
// RULE3 - Sixteen communication inputs, numbered 9 to 24, may carry codes too.
// RULE4 - Configuring party assigns interrupt code 49 only to hardware input 5.
// RULE5 - Limits and forced stop: hardware active when open, communication when set.
// RULE6 - Assignments are captured only at power-up, never while running.
// RULE7 - Unassigned enable and forced stop read on; other unassigned functions off.
// RULE8 - Code zero leaves an input unconnected and its state ignored.
`timescale 1ns/1ps
module ifa_input_function_assignment
	import ifa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [IFA_HW_N-1:0] externalInput,
	input wire logic [IFA_COMM_N-1:0] commInput,
	input wire logic [IFA_HW_N*IFA_CODE_W-1:0] hwAssign,
	input wire logic [IFA_COMM_N*IFA_CODE_W-1:0] commAssign,
	output logic driveEnable,
	output logic forwardRun,
	output logic reverseRun,
	output logic beginPositioning,
	output logic homingRequest,
	output logic positiveTravelLimit,
	output logic negativeTravelLimit,
	output logic forcedStop,
	output logic faultClear,
	output logic [IFA_ADDR_W-1:0] positionAddress
);
	ifa_pin_if pinBus ();

	ifa_pin_sync u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.pinRaw(externalInput),
		.pins(pinBus)
	);

	// Codes captured at power-up, one per input
	ifa_code_t code_q [IFA_IN_N];
	ifa_code_t code_d [IFA_IN_N];
	logic [IFA_IN_N-1:0] level;
	logic [IFA_IN_N-1:0] active;

	function automatic logic isBreakContact(input ifa_code_t c);
		isBreakContact = (c == IFA_FN_POS_LIMIT) || (c == IFA_FN_NEG_LIMIT)
			|| (c == IFA_FN_FORCED_STOP);
	endfunction : isBreakContact

	// Any input carrying the code, OR of the active levels
	function automatic logic anyActive(
		input ifa_code_t c,
		input logic [IFA_IN_N-1:0] act,
		input ifa_code_t codes [IFA_IN_N]
	);
		anyActive = 1'h0;
		for (int i = 0; i < IFA_IN_N; i++)
		begin
			if (codes[i] == c)
				anyActive = anyActive | act[i];
		end
	endfunction : anyActive

	function automatic logic isAssigned(
		input ifa_code_t c,
		input ifa_code_t codes [IFA_IN_N]
	);
		isAssigned = 1'h0;
		for (int i = 0; i < IFA_IN_N; i++)
		begin
			if (codes[i] == c)
				isAssigned = 1'h1;
		end
	endfunction : isAssigned

	// Address bits use consecutive codes from bit 0 upwards
	function automatic ifa_code_t addrCode(input int b);
		addrCode = IFA_FN_ADDR_BIT0 + ifa_code_t'(b);
	endfunction : addrCode

	// Settings are sampled only while reset is held, so edits take effect next power-up
	always_comb
	begin
		for (int i = 0; i < IFA_IN_N; i++)
		begin
			code_d[i] = code_q[i];
		end
		if (reset)
		begin
			for (int i = 0; i < IFA_HW_N; i++)
			begin
				code_d[i] = hwAssign[i*IFA_CODE_W +: IFA_CODE_W]; // RULE2 RULE6
			end
			for (int i = 0; i < IFA_COMM_N; i++)
			begin
				code_d[IFA_HW_N+i] = commAssign[i*IFA_CODE_W +: IFA_CODE_W]; // RULE3 RULE6
			end
		end
	end

	// No reset: the codes are reloaded on every edge while reset is held
	always_ff @(posedge clk_sys)
	begin
		for (int i = 0; i < IFA_IN_N; i++)
		begin
			code_q[i] <= code_d[i];
		end
	end

	// Hardware inputs first, communication inputs 9 to 24 follow
	assign level = {commInput, pinBus.level}; // RULE3

	// Hardware terminals: limits and forced stop are break contacts
	always_comb
	begin
		for (int i = 0; i < IFA_HW_N; i++)
		begin
			if (code_q[i] == IFA_FN_NONE)
				active[i] = 1'h0; // RULE8
			else if (isBreakContact(code_q[i]))
				active[i] = ~level[i]; // RULE5
			else
				active[i] = level[i];
		end
		// Communication inputs: every function is active when set
		for (int i = IFA_HW_N; i < IFA_IN_N; i++)
		begin
			if (code_q[i] == IFA_FN_NONE)
				active[i] = 1'h0; // RULE8
			else
				active[i] = level[i]; // RULE5
		end
	end

	// Next and registered values of the function outputs
	logic driveEnable_d;
	logic forwardRun_d;
	logic reverseRun_d;
	logic beginPositioning_d;
	logic homingRequest_d;
	logic positiveTravelLimit_d;
	logic negativeTravelLimit_d;
	logic forcedStop_d;
	logic faultClear_d;
	logic [IFA_ADDR_W-1:0] positionAddress_d;
	logic driveEnable_q;
	logic forwardRun_q;
	logic reverseRun_q;
	logic beginPositioning_q;
	logic homingRequest_q;
	logic positiveTravelLimit_q;
	logic negativeTravelLimit_q;
	logic forcedStop_q;
	logic faultClear_q;
	logic [IFA_ADDR_W-1:0] positionAddress_q;
	logic enableAssigned;
	logic stopAssigned;

	// Only enable and forced stop read as on when no input carries them
	assign enableAssigned = isAssigned(IFA_FN_DRIVE_ENABLE, code_q); // RULE7
	assign stopAssigned = isAssigned(IFA_FN_FORCED_STOP, code_q); // RULE7

	// Interrupt code 49 is not routed here; hardware input 5 is trusted to carry it
	always_comb
	begin
		if (reset)
		begin
			// Stop held engaged and motion off until the codes have settled
			driveEnable_d = 1'h0;
			forwardRun_d = 1'h0;
			reverseRun_d = 1'h0;
			beginPositioning_d = 1'h0;
			homingRequest_d = 1'h0;
			positiveTravelLimit_d = 1'h0;
			negativeTravelLimit_d = 1'h0;
			forcedStop_d = 1'h1;
			faultClear_d = 1'h0;
			positionAddress_d = IFA_ADDR_RESET;
		end
		else
		begin
			driveEnable_d = enableAssigned
				? anyActive(IFA_FN_DRIVE_ENABLE, active, code_q) : 1'h1; // RULE1 RULE7
			forwardRun_d = anyActive(IFA_FN_FORWARD_RUN, active, code_q); // RULE1 RULE7
			reverseRun_d = anyActive(IFA_FN_REVERSE_RUN, active, code_q); // RULE1
			beginPositioning_d = anyActive(IFA_FN_BEGIN_POS, active, code_q); // RULE1
			homingRequest_d = anyActive(IFA_FN_HOMING_REQUEST, active, code_q); // RULE1
			positiveTravelLimit_d = anyActive(IFA_FN_POS_LIMIT, active, code_q); // RULE1
			negativeTravelLimit_d = anyActive(IFA_FN_NEG_LIMIT, active, code_q); // RULE1
			// Stop engaged level; unassigned means signal on, so no stop
			forcedStop_d = stopAssigned
				? anyActive(IFA_FN_FORCED_STOP, active, code_q) : 1'h0; // RULE1 RULE7
			faultClear_d = anyActive(IFA_FN_FAULT_CLEAR, active, code_q); // RULE1
			for (int b = 0; b < IFA_ADDR_W; b++)
				positionAddress_d[b] = anyActive(addrCode(b), active, code_q); // RULE1
		end
	end

	always_ff @(posedge clk_sys)
	begin
		driveEnable_q <= driveEnable_d;
		forwardRun_q <= forwardRun_d;
		reverseRun_q <= reverseRun_d;
		beginPositioning_q <= beginPositioning_d;
		homingRequest_q <= homingRequest_d;
		positiveTravelLimit_q <= positiveTravelLimit_d;
		negativeTravelLimit_q <= negativeTravelLimit_d;
		forcedStop_q <= forcedStop_d;
		faultClear_q <= faultClear_d;
		positionAddress_q <= positionAddress_d;
	end

	assign driveEnable = driveEnable_q;
	assign forwardRun = forwardRun_q;
	assign reverseRun = reverseRun_q;
	assign beginPositioning = beginPositioning_q;
	assign homingRequest = homingRequest_q;
	assign positiveTravelLimit = positiveTravelLimit_q;
	assign negativeTravelLimit = negativeTravelLimit_q;
	assign forcedStop = forcedStop_q;
	assign faultClear = faultClear_q;
	assign positionAddress = positionAddress_q;
endmodule : ifa_input_function_assignment

// ===== verif/ifa_properties.sv
// Port checker for the input function assignment block
`timescale 1ns/1ps
module ifa_checker
	import ifa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [IFA_HW_N-1:0] externalInput,
	input wire logic [IFA_COMM_N-1:0] commInput,
	input wire logic [IFA_HW_N*IFA_CODE_W-1:0] hwAssign,
	input wire logic [IFA_COMM_N*IFA_CODE_W-1:0] commAssign,
	input wire logic driveEnable,
	input wire logic forwardRun,
	input wire logic faultClear,
	input wire logic positiveTravelLimit,
	input wire logic forcedStop,
	input wire logic [IFA_ADDR_W-1:0] positionAddress
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [1:0] up_q;
	logic [IFA_HW_N*IFA_CODE_W-1:0] hw_q;
	logic [IFA_COMM_N*IFA_CODE_W-1:0] cm_q;
	// Own copy of the codes, taken exactly as the block takes them
	always_ff @(posedge clk_sys)
	begin
		up_q <= reset ? 2'h0 : {up_q[0], 1'h1};
		if (reset)
		begin
			hw_q <= hwAssign;
			cm_q <= commAssign;
		end
	end
	// Set when some communication input carrying the code is set
	function automatic logic commOn(input ifa_code_t c, input logic [IFA_COMM_N-1:0] on,
		input logic [IFA_COMM_N*IFA_CODE_W-1:0] codes);
		commOn = 1'h0;
		for (int i = 0; i < IFA_COMM_N; i++)
			if (on[i] && codes[i*IFA_CODE_W +: IFA_CODE_W] == c)
				commOn = 1'h1;
	endfunction : commOn
	wire logic live = up_q[1];
	wire logic fwdOn = live && commOn(IFA_FN_FORWARD_RUN, commInput, cm_q);
	wire logic clrOn = live && commOn(IFA_FN_FAULT_CLEAR, commInput, cm_q);
	wire logic adrOn = live && commOn(IFA_FN_ADDR_BIT0, commInput, cm_q);
	wire logic limOn = live && commOn(IFA_FN_POS_LIMIT, commInput, cm_q);
	property p_rst; disable iff (1'h0) reset |=> forcedStop && !driveEnable && !forwardRun; endproperty
	a_rst: assert property (p_rst) else $error("bad reset outputs");
	property p_fwd; fwdOn |=> forwardRun; endproperty
	a_fwd: assert property (p_fwd) else $error("forward run missing");
	property p_clr; clrOn |=> faultClear; endproperty
	a_clr: assert property (p_clr) else $error("fault clear missing");
	property p_adr; adrOn |=> positionAddress[0]; endproperty
	a_adr: assert property (p_adr) else $error("address bit missing");
	property p_lim; limOn |=> positiveTravelLimit; endproperty
	a_lim: assert property (p_lim) else $error("comm limit missing");
	property p_hw; (live && hw_q[6:0] == 7'h07 && !externalInput[0]) [*7] |-> positiveTravelLimit; endproperty
	a_hw: assert property (p_hw) else $error("open contact limit missing");
	property p_stop; (live && hw_q[20:14] == 7'h0A && !externalInput[2]) [*7] |-> forcedStop; endproperty
	a_stop: assert property (p_stop) else $error("open contact stop missing");
	property p_none; live && hw_q == '0 && cm_q == '0 |=> driveEnable && !forcedStop && !forwardRun; endproperty
	a_none: assert property (p_none) else $error("unassigned levels wrong");
endmodule : ifa_checker
bind ifa_input_function_assignment ifa_checker chk (.clk_sys, .reset, .externalInput, .commInput,
	.hwAssign, .commAssign, .driveEnable, .forwardRun, .faultClear, .positiveTravelLimit,
	.forcedStop, .positionAddress);

// ===== verif/ifa_field_switches.sv
// Field contact model driving the hardware terminals
`timescale 1ns/1ps
module ifa_field_switches
	import ifa_pkg::*;
(
	input wire logic [IFA_HW_N-1:0] contactClosed,
	output logic [IFA_HW_N-1:0] externalInput
);
	// Closed contact pulls the terminal high
	assign externalInput = contactClosed;
endmodule : ifa_field_switches

// ===== verif/tb_top.sv
// Self-checking bench for the input function assignment block
`timescale 1ns/1ps
module tb_top;
	import ifa_pkg::*;
	logic clk_sys = 1'h0;
	logic reset = 1'h1;
	logic [5:0] contactClosed = '0;
	logic [5:0] externalInput;
	logic [15:0] commInput = '0;
	logic [41:0] hwAssign = '0;
	logic [111:0] commAssign = '0;
	logic [111:0] cm = '0;
	logic driveEnable, forwardRun, reverseRun, beginPositioning, homingRequest;
	logic positiveTravelLimit, negativeTravelLimit, forcedStop, faultClear;
	logic [3:0] positionAddress;
	int nErrors = 0;
	int numChecks = 0;
	int cycles = 0;
	ifa_code_t codes [15] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h07, 7'h08, 7'h0A, 7'h0B,
		7'h3F, 7'h3E, 7'h3D, 7'h3C, 7'h10, 7'h0E};
	wire logic [12:0] outs = {driveEnable, forwardRun, reverseRun, beginPositioning,
		homingRequest, positiveTravelLimit, negativeTravelLimit, forcedStop, faultClear,
		positionAddress};
	ifa_field_switches sw (.contactClosed(contactClosed), .externalInput(externalInput));
	ifa_input_function_assignment uut (.clk_sys(clk_sys), .reset(reset),
		.externalInput(externalInput), .commInput(commInput), .hwAssign(hwAssign),
		.commAssign(commAssign), .driveEnable(driveEnable), .forwardRun(forwardRun),
		.reverseRun(reverseRun), .beginPositioning(beginPositioning),
		.homingRequest(homingRequest), .positiveTravelLimit(positiveTravelLimit),
		.negativeTravelLimit(negativeTravelLimit), .forcedStop(forcedStop),
		.faultClear(faultClear), .positionAddress(positionAddress));
	always #5 clk_sys = ~clk_sys;
	task automatic stopTest();
		if (nErrors == 0 && numChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stopTest
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 500)
		begin
			nErrors++;
			stopTest();
		end
	end
	task automatic check(string what, logic [12:0] exp);
		numChecks++;
		if (outs !== exp)
		begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, outs);
		end
	endtask : check
	task automatic powerUp(logic [41:0] hw, logic [111:0] cmIn);
		reset = 1'h1;
		hwAssign = hw;
		commAssign = cmIn;
		repeat (16) @(posedge clk_sys);
		#1 check("reset outputs", 13'h0020);
		reset = 1'h0;
		repeat (3) @(posedge clk_sys);
		#1 commAssign = '0;
	endtask : powerUp
	initial
	begin
		contactClosed = 6'h2A;
		commInput = 16'hFFFF;
		powerUp('0, '0);
		repeat (7) @(posedge clk_sys);
		#1 check("unassigned", 13'h1000);
		for (int i = 0; i < 15; i++)
			cm[7*i +: 7] = codes[i];
		commInput = '0;
		// Codes cleared after release must leave routing untouched
		powerUp('0, cm);
		for (int i = 0; i < 15; i++)
		begin
			commInput = 16'h0001 << i;
			@(posedge clk_sys);
			#1 check("comm route", i < 13 ? 13'h1000 >> i : 13'h0000);
		end
		commInput = '0;
		contactClosed = 6'h3F;
		powerUp({7'h3D, 7'h31, 7'h02, 7'h0A, 7'h08, 7'h07}, '0);
		repeat (6) @(posedge clk_sys);
		#1 check("closed contacts", 13'h1802);
		contactClosed = 6'h38;
		repeat (7) @(posedge clk_sys);
		#1 check("open contacts", 13'h18E2);
		stopTest();
	end
endmodule : tb_top
